// File: ioxtd_expander.sv
// Two-wire slave I/O expander with transition detect
//
// Functional notes
// - Each of eight ports is independently an input or an output.
// - Four push-pull ports; four open-drain ports that only pull low.
// - Every port set as input is watched for level changes.
// - A detected input change asserts the interrupt pin.
// - The interrupt stays latched after the input returns.
// - Each serial read byte clears the pending interrupt unless an input port still differs from the previous snapshot.
// - Interrupt pin pulls low when asserted, otherwise undriven.
// - Interface reset returns serial logic to idle, aborting transfers.
// - Interface reset pin is active low; high is inactive.
// - Slave address picks one of two values from the select pin.
// - Power-up port state follows the address select level.
// - Standard two-wire slave, serial clock up to fast-mode rate.
`timescale 1ns/10ps
`default_nettype none
module ioxtd_expander
#(
   parameter logic [6:0] SLAVE_ADDR = ioxtd_pkg::SLAVE_ADDR_BASE
)
(
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   input  wire logic       iface_reset_n_i,
   input  wire logic       addr_sel_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   input  wire logic [3:0] pushpull_port_i,
   output logic      [3:0] pushpull_port_o,
   output logic      [3:0] pushpull_port_oe_o,
   input  wire logic [3:0] opendrain_port_i,
   output logic      [3:0] opendrain_port_o,
   output logic      [3:0] opendrain_port_oe_o,
   output logic            change_irq_n_o,
   output logic            change_irq_n_oe_o
);
   import ioxtd_pkg::*;

   logic [SYNC_WIDTH-1:0] sync_bus;
   logic                  scl_s;
   logic                  sda_s;
   logic                  rstn_s;
   logic                  addr_s;
   logic [7:0]            levels_s;

   logic                  scl_prev_reg;
   logic                  sda_prev_reg;
   logic                  scl_rise;
   logic                  scl_fall;
   logic                  bus_start;
   logic                  bus_stop;

   ioxtd_state_t          state_reg;
   ioxtd_state_t          state_next;
   logic [7:0]            shift_reg;
   logic [7:0]            shift_next;
   logic [3:0]            bit_reg;
   logic [3:0]            bit_next;
   logic                  drive_low_reg;
   logic                  drive_low_next;
   logic                  rw_reg;
   logic                  rw_next;
   logic                  ack_reg;
   logic                  ack_next;
   logic [1:0]            idx_reg;
   logic [1:0]            idx_next;
   logic                  wr_stb;
   logic                  rd_load;
   logic [6:0]            my_addr;

   logic [7:0]            dir_reg;
   logic [7:0]            dir_next;
   logic [7:0]            level_reg;
   logic [7:0]            level_next;
   logic [1:0]            strap_cnt_reg;
   logic [1:0]            strap_cnt_next;
   logic                  strap_done_reg;
   logic                  strap_done_next;
   logic                  strap_load;

   logic                  irq_pending;
   logic                  irq_reg;
   logic                  irq_next;

   // Every input pin except rst_i goes through two flops; 25 MHz sampling oversamples fast-mode clock
   ioxtd_sync
   #(
      .WIDTH       (SYNC_WIDTH),
      .RESET_VALUE (SYNC_RESET_VAL)
   )
   u_sync
   (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .async_i    ({opendrain_port_i, pushpull_port_i, addr_sel_i, iface_reset_n_i, sda_i, scl_i}),
      .sync_o     (sync_bus)
   );

   assign scl_s    = sync_bus[SYN_SCL];
   assign sda_s    = sync_bus[SYN_SDA];
   assign rstn_s   = sync_bus[SYN_RSTN];
   assign addr_s   = sync_bus[SYN_ADDR];
   assign levels_s = sync_bus[SYN_PORT_LSB +: NUM_PORTS];

   // Edge and condition detection on the synchronised bus lines
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end
      else
      begin
         scl_prev_reg <= scl_s;
         sda_prev_reg <= sda_s;
      end
   end

   assign scl_rise  = scl_s & ~scl_prev_reg;
   assign scl_fall  = ~scl_s & scl_prev_reg;
   assign bus_start = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
   assign bus_stop  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

   assign my_addr = {SLAVE_ADDR[6:1], addr_s};

   // Serial slave engine
   always_comb
   begin
      state_next     = state_reg;
      shift_next     = shift_reg;
      bit_next       = bit_reg;
      drive_low_next = drive_low_reg;
      rw_next        = rw_reg;
      ack_next       = ack_reg;
      idx_next       = idx_reg;
      wr_stb         = 1'b0;
      rd_load        = 1'b0;
      if (!rstn_s)
      begin
         // Abort any transfer and release the data line
         state_next     = ST_IDLE;
         bit_next       = 4'h0;
         drive_low_next = 1'b0;
      end
      else if (bus_start)
      begin
         state_next     = ST_ADDR;
         bit_next       = 4'h0;
         drive_low_next = 1'b0;
      end
      else if (bus_stop)
      begin
         state_next     = ST_IDLE;
         drive_low_next = 1'b0;
      end
      else
      begin
         case (state_reg)
            ST_IDLE:
            begin
               drive_low_next = 1'b0;
            end
            ST_ADDR:
            begin
               if (scl_rise)
               begin
                  shift_next = {shift_reg[6:0], sda_s};
                  bit_next   = bit_reg + 4'h1;
               end
               else if (scl_fall && bit_reg == BITS_PER_BYTE)
               begin
                  if (shift_reg[7:1] == my_addr)
                  begin
                     state_next     = ST_ADDR_ACK;
                     drive_low_next = 1'b1;
                     rw_next        = shift_reg[0];
                  end
                  else
                  begin
                     state_next = ST_IDLE;
                  end
               end
            end
            ST_ADDR_ACK:
            begin
               if (scl_fall)
               begin
                  bit_next = 4'h0;
                  if (rw_reg)
                  begin
                     state_next     = ST_RD_BYTE;
                     rd_load        = 1'b1;
                     shift_next     = levels_s;
                     drive_low_next = ~levels_s[7];
                  end
                  else
                  begin
                     state_next     = ST_WR_BYTE;
                     drive_low_next = 1'b0;
                     idx_next       = WR_IDX_LEVEL;
                  end
               end
            end
            ST_WR_BYTE:
            begin
               if (scl_rise)
               begin
                  shift_next = {shift_reg[6:0], sda_s};
                  bit_next   = bit_reg + 4'h1;
               end
               else if (scl_fall && bit_reg == BITS_PER_BYTE)
               begin
                  wr_stb         = 1'b1;
                  state_next     = ST_WR_ACK;
                  drive_low_next = 1'b1;
                  // Extra bytes are acknowledged and dropped
                  if (idx_reg != WR_IDX_LAST)
                  begin
                     idx_next = idx_reg + 2'h1;
                  end
               end
            end
            ST_WR_ACK:
            begin
               if (scl_fall)
               begin
                  state_next     = ST_WR_BYTE;
                  drive_low_next = 1'b0;
                  bit_next       = 4'h0;
               end
            end
            ST_RD_BYTE:
            begin
               if (scl_rise)
               begin
                  bit_next = bit_reg + 4'h1;
               end
               else if (scl_fall)
               begin
                  if (bit_reg == BITS_PER_BYTE)
                  begin
                     state_next     = ST_RD_ACK;
                     drive_low_next = 1'b0;
                  end
                  else
                  begin
                     shift_next     = {shift_reg[6:0], 1'b0};
                     drive_low_next = ~shift_reg[6];
                  end
               end
            end
            ST_RD_ACK:
            begin
               if (scl_rise)
               begin
                  ack_next = ~sda_s;
               end
               else if (scl_fall)
               begin
                  bit_next = 4'h0;
                  if (ack_reg)
                  begin
                     // Each further byte is a fresh read of the ports
                     state_next     = ST_RD_BYTE;
                     rd_load        = 1'b1;
                     shift_next     = levels_s;
                     drive_low_next = ~levels_s[7];
                  end
                  else
                  begin
                     state_next = ST_IDLE;
                  end
               end
            end
            default:
            begin
               state_next     = ST_IDLE;
               drive_low_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_reg     <= ST_IDLE;
         shift_reg     <= 8'h00;
         bit_reg       <= 4'h0;
         drive_low_reg <= 1'b0;
         rw_reg        <= 1'b0;
         ack_reg       <= 1'b0;
         idx_reg       <= 2'h0;
      end
      else
      begin
         state_reg     <= state_next;
         shift_reg     <= shift_next;
         bit_reg       <= bit_next;
         drive_low_reg <= drive_low_next;
         rw_reg        <= rw_next;
         ack_reg       <= ack_next;
         idx_reg       <= idx_next;
      end
   end

   // Port configuration; strap waits out the synchroniser after reset
   assign strap_load = ~strap_done_reg & (strap_cnt_reg == STRAP_WAIT);

   always_comb
   begin
      dir_next        = dir_reg;
      level_next      = level_reg;
      strap_cnt_next  = strap_cnt_reg;
      strap_done_next = strap_done_reg;
      if (!strap_done_reg)
      begin
         strap_cnt_next = strap_cnt_reg + 2'h1;
      end
      if (strap_load)
      begin
         strap_done_next = 1'b1;
         dir_next        = addr_s ? DIR_ALL_OUTPUT : DIR_ALL_INPUT;
         level_next      = LEVEL_ALL_LOW;
      end
      else if (wr_stb && idx_reg == WR_IDX_LEVEL)
      begin
         level_next = shift_reg;
      end
      else if (wr_stb && idx_reg == WR_IDX_DIR)
      begin
         dir_next = shift_reg;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         dir_reg        <= DIR_ALL_INPUT;
         level_reg      <= LEVEL_ALL_HIGH;
         strap_cnt_reg  <= 2'h0;
         strap_done_reg <= 1'b0;
      end
      else
      begin
         dir_reg        <= dir_next;
         level_reg      <= level_next;
         strap_cnt_reg  <= strap_cnt_next;
         strap_done_reg <= strap_done_next;
      end
   end

   // Nothing watched until the strap snapshot, so reset levels cannot fire a change
   ioxtd_change_latch
   #(
      .WIDTH (NUM_PORTS)
   )
   u_change
   (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .level_i    (levels_s),
      .watch_i    (strap_done_reg ? dir_reg : DIR_ALL_OUTPUT),
      .capture_i  (rd_load | strap_load),
      .clear_i    (rd_load),
      .pending_o  (irq_pending)
   );

   always_comb
   begin
      irq_next = irq_pending;
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         irq_reg <= 1'b0;
      end
      else
      begin
         irq_reg <= irq_next;
      end
   end

   assign sda_o               = 1'b0;
   assign sda_oe_o            = drive_low_reg;
   assign change_irq_n_o      = 1'b0;
   assign change_irq_n_oe_o   = irq_reg;
   assign pushpull_port_o     = level_reg[PP_LSB +: NUM_PUSHPULL];
   assign pushpull_port_oe_o  = ~dir_reg[PP_LSB +: NUM_PUSHPULL];
   // Open-drain group never drives high
   assign opendrain_port_o    = 4'h0;
   assign opendrain_port_oe_o = ~dir_reg[OD_LSB +: NUM_OPENDRAIN] & ~level_reg[OD_LSB +: NUM_OPENDRAIN];

endmodule : ioxtd_expander
`default_nettype wire

// File: ioxtd_pkg.sv
// Shared constants for the transition-detect I/O expander
package ioxtd_pkg;

   localparam int          NUM_PORTS       = 8;
   localparam int          NUM_PUSHPULL    = 4;
   localparam int          NUM_OPENDRAIN   = 4;
   localparam int          PP_LSB          = 0;
   localparam int          OD_LSB          = 4;

   // Base slave address, bit 0 replaced by the address-select pin; value arbitrary
   localparam logic [6:0]  SLAVE_ADDR_BASE = 7'h2C;

   // Write data byte order after the address byte
   localparam logic [1:0]  WR_IDX_LEVEL    = 2'h0;
   localparam logic [1:0]  WR_IDX_DIR      = 2'h1;
   localparam logic [1:0]  WR_IDX_LAST     = 2'h2;

   // Direction bit: 1 = input, 0 = output
   localparam logic [7:0]  DIR_ALL_INPUT   = 8'hFF;
   localparam logic [7:0]  DIR_ALL_OUTPUT  = 8'h00;
   localparam logic [7:0]  LEVEL_ALL_LOW   = 8'h00;
   localparam logic [7:0]  LEVEL_ALL_HIGH  = 8'hFF;

   localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
   localparam logic [1:0]  STRAP_WAIT      = 2'h3;

   // Synchroniser bit positions and reset pattern
   localparam int          SYNC_WIDTH      = 12;
   localparam int          SYN_SCL         = 0;
   localparam int          SYN_SDA         = 1;
   localparam int          SYN_RSTN        = 2;
   localparam int          SYN_ADDR        = 3;
   localparam int          SYN_PORT_LSB    = 4;
   localparam logic [11:0] SYNC_RESET_VAL  = 12'h007;

   // Sampling rate against the fastest serial clock
   localparam int          CORE_CLK_HZ     = 25000000;
   localparam int          SCL_MAX_HZ      = 400000;
   localparam int          SCL_MIN_CYCLES  = CORE_CLK_HZ / SCL_MAX_HZ;

   typedef enum logic [2:0]
   {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WR_BYTE,
      ST_WR_ACK,
      ST_RD_BYTE,
      ST_RD_ACK
   } ioxtd_state_t;

endpackage : ioxtd_pkg

// File: ioxtd_sync.sv
// Two-flop synchroniser for a bundle of asynchronous inputs
`timescale 1ns/10ps
`default_nettype none
module ioxtd_sync
#(
   parameter int               WIDTH       = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
   input  wire logic             core_clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;
   logic [WIDTH-1:0] stage1_next;
   logic [WIDTH-1:0] stage2_next;

   always_comb
   begin
      stage1_next = async_i;
      stage2_next = stage1_reg;
   end

   // First stage feeds only the second
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         stage1_reg <= RESET_VALUE;
         stage2_reg <= RESET_VALUE;
      end
      else
      begin
         stage1_reg <= stage1_next;
         stage2_reg <= stage2_next;
      end
   end

   assign sync_o = stage2_reg;

endmodule : ioxtd_sync
`default_nettype wire

// File: ioxtd_change_latch.sv
// Input snapshot and latched change flag
`timescale 1ns/10ps
`default_nettype none
module ioxtd_change_latch
#(
   parameter int WIDTH = 8
)
(
   input  wire logic             core_clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] level_i,
   input  wire logic [WIDTH-1:0] watch_i,
   input  wire logic             capture_i,
   input  wire logic             clear_i,
   output logic                  pending_o
);

   logic [WIDTH-1:0] snap_reg;
   logic [WIDTH-1:0] snap_next;
   logic             pending_reg;
   logic             pending_next;
   logic             differs;

   always_comb
   begin
      // Only ports set as inputs are compared
      differs      = |((level_i ^ snap_reg) & watch_i);
      snap_next    = capture_i ? level_i : snap_reg;
      // Set wins over clear in the same cycle
      pending_next = (pending_reg & ~clear_i) | differs;
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         snap_reg    <= '0;
         pending_reg <= 1'b0;
      end
      else
      begin
         snap_reg    <= snap_next;
         pending_reg <= pending_next;
      end
   end

   assign pending_o = pending_reg;

endmodule : ioxtd_change_latch
`default_nettype wire

// File: ioxtd_assertions.sv
// Concurrent checks on the expander's pins
`timescale 1ns/10ps
`default_nettype none
module ioxtd_assertions
(
   input wire logic       core_clk_i,
   input wire logic       rst_i,
   input wire logic       iface_reset_n_i,
   input wire logic       addr_sel_i,
   input wire logic       scl_i,
   input wire logic       sda_i,
   input wire logic       sda_o,
   input wire logic       sda_oe_o,
   input wire logic [3:0] pushpull_port_i,
   input wire logic [3:0] pushpull_port_o,
   input wire logic [3:0] pushpull_port_oe_o,
   input wire logic [3:0] opendrain_port_i,
   input wire logic [3:0] opendrain_port_o,
   input wire logic [3:0] opendrain_port_oe_o,
   input wire logic       change_irq_n_o,
   input wire logic       change_irq_n_oe_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   property p_irq_od;
      change_irq_n_oe_o |-> !change_irq_n_o;
   endproperty
   a_irq_od: assert property (p_irq_od) else $error("interrupt pin driven high");

   property p_od_low;
      |opendrain_port_oe_o |-> (opendrain_port_o & opendrain_port_oe_o) == 4'h0;
   endproperty
   a_od_low: assert property (p_od_low) else $error("open-drain port driven high");

   // Only checked with the bus clock high, so no read can clear in the window
   property p_change;
      (scl_i && $stable(pushpull_port_oe_o) && |(~pushpull_port_oe_o & (pushpull_port_i ^ $past(pushpull_port_i))))
      ##1 (scl_i && $stable(pushpull_port_i) && $stable(pushpull_port_oe_o))[*5] |-> change_irq_n_oe_o;
   endproperty
   a_change: assert property (p_change) else $error("input change not flagged");

   property p_latched;
      (change_irq_n_oe_o && scl_i)[*3] |=> change_irq_n_oe_o;
   endproperty
   a_latched: assert property (p_latched) else $error("interrupt dropped without read");

   property p_clear;
      $fell(change_irq_n_oe_o) |-> !$past(scl_i, 2) || !$past(scl_i, 3);
   endproperty
   a_clear: assert property (p_clear) else $error("interrupt cleared off a bus clock fall");

   property p_iface;
      (!iface_reset_n_i)[*4] |=> !sda_oe_o;
   endproperty
   a_iface: assert property (p_iface) else $error("data line held in interface reset");

   property p_ack_edge;
      $rose(sda_oe_o) |-> !$past(scl_i);
   endproperty
   a_ack_edge: assert property (p_ack_edge) else $error("data line grabbed with clock high");

   property p_strap;
      $fell(rst_i) |-> ##5 (pushpull_port_oe_o == {4{addr_sel_i}} && opendrain_port_oe_o == {4{addr_sel_i}});
   endproperty
   a_strap: assert property (p_strap) else $error("power-up port state wrong");

   c_ack: cover property ($rose(sda_oe_o));
   c_irq: cover property ($rose(change_irq_n_oe_o));
   c_clear: cover property ($fell(change_irq_n_oe_o));
   c_ifrst: cover property ($fell(iface_reset_n_i));
endmodule : ioxtd_assertions
`default_nettype wire

// File: ioxtd_i2c_master.sv
// Behavioural two-wire bus master for the expander
`timescale 1ns/10ps
`default_nettype none
module ioxtd_i2c_master
(
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   // Half bus period in ns; bench runs well above fast mode to save time
   int half = 160;

   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   task automatic bitx(input logic b, output logic s);
      #(half / 2) sda_o = b;
      #(half / 2) scl_o = 1'b1;
      #(half / 2) s = sda_i;
      #(half / 2) scl_o = 1'b0;
   endtask : bitx

   // Quarter periods are whole clocks, so bus edges keep the caller's offset
   task automatic start();
      sda_o = 1'b1;
      #(half / 2) scl_o = 1'b1;
      #(half / 2) sda_o = 1'b0;
      #(half / 2) scl_o = 1'b0;
   endtask : start

   task automatic stop();
      #(half / 2) sda_o = 1'b0;
      #(half / 2) scl_o = 1'b1;
      #(half / 2) sda_o = 1'b1;
      #1320;
   endtask : stop

   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bitx(b[i], s);
      bitx(1'b1, s);
      ack = !s;
   endtask : wbyte

   task automatic rbyte(input logic more, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bitx(1'b1, s);
         b[i] = s;
      end
      bitx(!more, s);
   endtask : rbyte
endmodule : ioxtd_i2c_master
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the transition-detect expander
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; $display("BAD %0t got %h exp %h", $time, got, exp); end end
module testbench;
   import ioxtd_pkg::*;
   logic       core_clk = 1'b0;
   logic       rst      = 1'b1;
   logic       ifrst_n  = 1'b1;
   logic       asel     = 1'b0;
   logic [7:0] ext      = 8'h00;
   logic       scl, msda, dut_sda, sda_oe, irq_n, irq_oe;
   logic [3:0] pp_o, pp_oe, od_o, od_oe;
   wire        sda_line = msda & ~(sda_oe & ~dut_sda);
   wire  [3:0] pp_pin   = (pp_oe & pp_o) | (~pp_oe & ext[3:0]);
   wire  [3:0] od_pin   = (od_oe & od_o) | (~od_oe & ext[7:4]);
   wire        irq_pin  = irq_oe ? irq_n : 1'b1;
   int         bad_count = 0;
   int         comparisons = 0;

   always #20 core_clk = ~core_clk;

   ioxtd_expander i_dut
   (
      .core_clk_i(core_clk), .rst_i(rst), .iface_reset_n_i(ifrst_n), .addr_sel_i(asel),
      .scl_i(scl), .sda_i(sda_line), .sda_o(dut_sda), .sda_oe_o(sda_oe),
      .pushpull_port_i(pp_pin), .pushpull_port_o(pp_o), .pushpull_port_oe_o(pp_oe),
      .opendrain_port_i(od_pin), .opendrain_port_o(od_o), .opendrain_port_oe_o(od_oe),
      .change_irq_n_o(irq_n), .change_irq_n_oe_o(irq_oe)
   );

   ioxtd_i2c_master i_mst (.sda_i(sda_line), .scl_o(scl), .sda_o(msda));

   function automatic logic [7:0] exp_pins(logic [7:0] l, logic [7:0] d, logic [7:0] x);
      logic [7:0] p;
      p[3:0] = (d[3:0] & x[3:0]) | (~d[3:0] & l[3:0]);
      p[7:4] = x[7:4] & (d[7:4] | l[7:4]);
      return p;
   endfunction : exp_pins

   task automatic tick(int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   task automatic wr(input logic sel, input logic [7:0] l, input logic [7:0] d, output logic ack);
      logic a1, a2, a3;
      i_mst.start();
      i_mst.wbyte({SLAVE_ADDR_BASE[6:1], sel, 1'b0}, a1);
      i_mst.wbyte(l, a2);
      i_mst.wbyte(d, a3);
      i_mst.stop();
      ack = a1 & a2 & a3;
   endtask : wr

   task automatic rd(input logic sel, output logic ack, output logic [7:0] b0, output logic [7:0] b1);
      i_mst.start();
      i_mst.wbyte({SLAVE_ADDR_BASE[6:1], sel, 1'b1}, ack);
      i_mst.rbyte(1'b1, b0);
      i_mst.rbyte(1'b0, b1);
      i_mst.stop();
   endtask : rd

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test

   initial
   begin
      repeat (90000) @(posedge core_clk);
      bad_count++;
      stop_test();
   end

   initial
   begin
      logic       ack;
      logic [7:0] b0, b1, l, d, old, n;
      void'($urandom(32'hDBFFFF2D));
      ext = 8'($urandom());
      tick(6);
      rst = 1'b0;
      tick(8);
      `CHK({pp_oe, od_oe}, 8'h00)
      `CHK(irq_pin, 1'b1)
      rd(1'b1, ack, b0, b1);
      `CHK(ack, 1'b0)
      rd(1'b0, ack, b0, b1);
      `CHK(ack, 1'b1)
      `CHK(b1, exp_pins(8'hFF, 8'hFF, ext))
      for (int k = 0; k < 6; k++)
      begin
         // Alternate a prompt and a slow bus
         i_mst.half = (k % 2) ? 400 : 160;
         l = 8'($urandom());
         d = (k == 0) ? 8'hFF : (k == 5) ? 8'h00 : 8'($urandom());
         wr(1'b0, l, d, ack);
         `CHK(ack, 1'b1)
         `CHK({pp_oe, pp_o & pp_oe, od_oe}, {~d[3:0], l[3:0] & ~d[3:0], ~d[7:4] & ~l[7:4]})
         rd(1'b0, ack, b0, b1);
         `CHK(b1, exp_pins(l, d, ext))
         tick(4);
         `CHK(irq_pin, 1'b1)
         old = ext;
         n = 8'($urandom());
         ext = n;
         tick(8);
         `CHK(irq_pin, ~|((n ^ old) & d))
         ext = old;
         tick(8);
         `CHK(irq_pin, ~|((n ^ old) & d))
         rd(1'b0, ack, b0, b1);
         `CHK(b0, exp_pins(l, d, old))
         tick(4);
         `CHK(irq_pin, 1'b1)
      end
      i_mst.start();
      i_mst.wbyte({SLAVE_ADDR_BASE[6:1], 2'b00}, ack);
      tick(1);
      ifrst_n = 1'b0;
      tick(12);
      ifrst_n = 1'b1;
      i_mst.wbyte(8'h00, ack);
      `CHK(ack, 1'b0)
      i_mst.stop();
      `CHK(pp_oe, ~d[3:0])
      tick(1);
      ifrst_n = 1'b0;
      rd(1'b0, ack, b0, b1);
      `CHK(ack, 1'b0)
      tick(1);
      ifrst_n = 1'b1;
      tick(30);
      rd(1'b0, ack, b0, b1);
      `CHK(ack, 1'b1)
      tick(1);
      asel = 1'b1;
      rst = 1'b1;
      tick(6);
      rst = 1'b0;
      tick(8);
      `CHK({pp_oe, pp_o, od_oe}, 12'hF0F)
      `CHK(irq_pin, 1'b1)
      wr(1'b0, 8'h00, 8'hFF, ack);
      `CHK(ack, 1'b0)
      rd(1'b1, ack, b0, b1);
      `CHK(ack, 1'b1)
      `CHK(b0, exp_pins(8'h00, 8'h00, ext))
      stop_test();
   end
endmodule : testbench

bind ioxtd_expander ioxtd_assertions i_chk
(
   .core_clk_i(core_clk_i), .rst_i(rst_i), .iface_reset_n_i(iface_reset_n_i), .addr_sel_i(addr_sel_i),
   .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .pushpull_port_i(pushpull_port_i), .pushpull_port_o(pushpull_port_o),
   .pushpull_port_oe_o(pushpull_port_oe_o), .opendrain_port_i(opendrain_port_i),
   .opendrain_port_o(opendrain_port_o), .opendrain_port_oe_o(opendrain_port_oe_o),
   .change_irq_n_o(change_irq_n_o), .change_irq_n_oe_o(change_irq_n_oe_o)
);
`default_nettype wire
